// File: bench/ssl_chk.sv
// Link checker for the slot, tracker and log setup block.
`timescale 1ns/1ps
`default_nettype none
module ssl_chk
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        cmdValid,
   input wire logic        cmdWrite,
   input wire logic [7:0]  cmdCode,
   input wire logic [15:0] cmdData,
   input wire logic        rspValid,
   input wire logic [15:0] rspData,
   input wire logic        devBusy
);
   import ssl_pkg::*;
   logic [1:0] sinceErase;
   wire logic  rdCmd = cmdValid && !cmdWrite;
   wire logic  eraseCmd = cmdValid && cmdWrite && cmdCode == CMD_LOGSET
                          && cmdData[BIT_ERASE];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Saturates at 3, so a busy spell with no erase order behind it shows.
   always_ff @(posedge sys_clk or negedge rstn)
      if (!rstn)
         sinceErase <= 2'h3;
      else if (eraseCmd)
         sinceErase <= 2'h0;
      else if (sinceErase != 2'h3)
         sinceErase <= sinceErase + 2'h1;
   chk_read_answer: assert property (rdCmd |=> rspValid)
      else $error("read got no answer");
   chk_write_silent: assert property
      (cmdValid && cmdWrite |=> !rspValid)
      else $error("write got an answer");
   chk_answer_cause: assert property (rspValid |-> $past(rdCmd))
      else $error("answer without a read");
   chk_idle_zero: assert property (!rspValid |-> rspData == 16'h0000)
      else $error("read data not zero outside answer");
   chk_slot_upper: assert property (rdCmd && cmdCode == CMD_SLOT
      |=> rspData[15:4] == 12'h000)
      else $error("slot upper bits not zero");
   chk_logset_spare: assert property (rdCmd && cmdCode == CMD_LOGSET
      |=> (rspData & ~LOGSET_MASK) == 16'h0000)
      else $error("log setup spare bits not zero");
   chk_busy_cause: assert property
      ($rose(devBusy) |-> sinceErase != 2'h3)
      else $error("busy without erase order");
   chk_busy_quiet: assert property
      (devBusy && $past(devBusy) |-> !cmdValid)
      else $error("command sent during erase");
endmodule : ssl_chk
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench: host register port driving the monitor end.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ssl_pkg::*;
   localparam int MSC = 10;
   logic        sys_clk, rstn, selSlot, run, voltValid, tempValid, regWr;
   logic        regRd, faultLow, faultIgn, logFull, shutdown, cmlFlag;
   logic        tick, freshReq, writeReq, eraseReq, eraseTwo, halt;
   logic [1:0]  regAddr, depthSel;
   logic [2:0]  pulses;
   logic [3:0]  actSlot, voltChan;
   logic [15:0] pmbEn, voltSample, tempSample, regWdata, regRdata;
   logic [15:0] supEn, rd, e;
   int          mismatches, numChecks, cycles, n;
   int          ivl[4] = '{INTERVAL_MS0, INTERVAL_MS1, INTERVAL_MS2,
                           INTERVAL_MS3};
   wire logic [3:0] reqs = {halt, eraseReq, freshReq, writeReq};
   ssl_cmd_if cmdLink ();
   ssl_device #(.NCH(16), .MS_CYC(MSC)) i_ssl_device (
      .sys_clk(sys_clk), .rstn(rstn), .bus(cmdLink),
      .slotSequencingSelect(selSlot), .sequenceRun(run),
      .activeSlot(actSlot), .pmbusEnable(pmbEn),
      .supplyEnableOutput(supEn), .voltValid(voltValid),
      .voltChan(voltChan), .voltSample(voltSample),
      .tempValid(tempValid), .tempSample(tempSample),
      .faultLineLow(faultLow), .faultIgnore(faultIgn),
      .globalShutdown(shutdown), .clearCml(pulses[2]),
      .commMemoryLogicFlag(cmlFlag), .collectTick(tick),
      .freshSampleReq(freshReq), .logWriteReq(writeReq),
      .logEraseReq(eraseReq), .logEraseTwo(eraseTwo),
      .logDepthSelect(depthSel), .logFull(logFull),
      .nvDone(pulses[0]), .nvFail(pulses[1]), .monitorHalt(halt));
   ssl_host i_ssl_host (.sys_clk(sys_clk), .rstn(rstn), .bus(cmdLink),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata));
   ssl_chk chk (.sys_clk(sys_clk), .rstn(rstn),
      .cmdValid(cmdLink.cmdValid), .cmdWrite(cmdLink.cmdWrite),
      .cmdCode(cmdLink.cmdCode), .cmdData(cmdLink.cmdData),
      .rspValid(cmdLink.rspValid), .rspData(cmdLink.rspData),
      .devBusy(cmdLink.devBusy));
   task automatic summarize();
      $display("Checks %0d mismatches %0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   task automatic check(input string nm, input logic [15:0] x,
      input logic [15:0] g);
      numChecks++;
      if (g !== x)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask : check
   task automatic regWrite(input logic [1:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask : regWrite
   task automatic regRead(input logic [1:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : regRead
   task automatic pollIdle();
      logic [15:0] s;
      int k = 0;
      do
      begin
         regRead(HA_STATUS, s);
         k++;
      end
      while (s[1:0] !== 2'b00 && k < 1000);
      check("link idle", 16'h0000, {14'h0, s[1:0]});
   endtask : pollIdle
   task automatic link(input logic w, input logic [7:0] c,
      input logic [3:0] p, input logic [15:0] d);
      regWrite(HA_WDATA, d);
      regWrite(HA_ORDER, {3'h0, w, p, c});
      pollIdle();
      if (!w)
         regRead(HA_RDATA, rd);
   endtask : link
   task automatic readChk(input string nm, input logic [7:0] c,
      input logic [3:0] p, input logic [15:0] x);
      link(1'b0, c, p, 16'h0000);
      check(nm, x, rd);
   endtask : readChk
   task automatic waitBit(input int b);
      int k = 0;
      while (reqs[b] !== 1'b1 && k < 40)
      begin
         @(posedge sys_clk);
         #1 k++;
      end
      check("request", 16'h0001, {15'h0, reqs[b]});
   endtask : waitBit
   task automatic pulse(input int b);
      @(posedge sys_clk);
      pulses[b] <= 1'b1;
      @(posedge sys_clk);
      pulses <= 3'h0;
   endtask : pulse
   task automatic sampleIn(input logic t, input logic [15:0] v);
      @(posedge sys_clk);
      voltValid <= !t;
      tempValid <= t;
      voltSample <= v;
      tempSample <= v;
      @(posedge sys_clk);
      voltValid <= 1'b0;
      tempValid <= 1'b0;
   endtask : sampleIn
   task automatic tickGap();
      n = 0;
      do
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      while (tick !== 1'b1 && n < 5000);
   endtask : tickGap
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // A hang anywhere ends in the same closing report.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         mismatches++;
         summarize();
      end
   end
   initial
   begin
      {rstn, selSlot, run, voltValid, tempValid, regWr, regRd} = 7'h00;
      {faultLow, faultIgn, logFull, pulses, actSlot, regAddr} = 12'h000;
      {voltSample, tempSample, regWdata} = 48'h0;
      pmbEn = 16'hA5C3;
      voltChan = 4'h2;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      readChk("vpeak", CMD_VPEAK, 2, VPEAK_RESET);
      readChk("tpeak", CMD_TPEAK, 0, TPEAK_RESET);
      readChk("vmin", CMD_VMIN, 2, VMIN_RESET);
      readChk("mean", CMD_TMEAN, 0, TMEAN_RESET);
      readChk("logset", CMD_LOGSET, 0, LOGSET_RESET);
      // Groups of four share a slot; the last channel jumps to slot 15.
      for (int i = 0; i < 16; i++)
         link(1'b1, CMD_SLOT, i[3:0],
              i == 15 ? 16'hFFFF : 16'(i / 4));
      readChk("slot", CMD_SLOT, 15, 16'h000F);
      check("pmbus mode", pmEn_fix(), supEn);
      selSlot <= 1'b1;
      run <= 1'b1;
      for (int k = 0; k < 16; k++)
      begin
         actSlot <= k[3:0];
         for (int i = 0; i < 16; i++)
            e[i] = (i == 15 ? 15 : i / 4) <= k;
         @(posedge sys_clk);
         #1 check("enables", e, supEn);
      end
      // With the sequence stopped no slot may enable its supply.
      run <= 1'b0;
      @(posedge sys_clk);
      #1 check("run off", 16'h0000, supEn);
      run <= 1'b1;
      link(1'b1, CMD_VPEAK, 2, 16'h0400);
      link(1'b1, CMD_VMIN, 2, 16'h0150);
      sampleIn(1'b0, 16'h0300);
      sampleIn(1'b0, 16'h0080);
      sampleIn(1'b0, 16'h0200);
      readChk("vpeak ref", CMD_VPEAK, 2, 16'h0400);
      readChk("vmin", CMD_VMIN, 2, 16'h0080);
      link(1'b1, CMD_VPEAK, 2, 16'h0000);
      readChk("vpeak clr", CMD_VPEAK, 2, 16'h0000);
      link(1'b1, CMD_TPEAK, 0, 16'h8000);
      sampleIn(1'b1, 16'hFFF0);
      readChk("tpeak", CMD_TPEAK, 0, 16'hFFF0);
      link(1'b1, CMD_TMEAN, 0, 16'h0000);
      sampleIn(1'b1, 16'h0040);
      link(1'b1, CMD_TMEAN, 0, 16'h1234);
      readChk("mean", CMD_TMEAN, 0, 16'h0040);
      link(1'b1, CMD_LOGSET, 0, 16'h07FF);
      readChk("logset", CMD_LOGSET, 0, 16'h07C0);
      check("wrap", 16'h0001, {15'h0, eraseTwo});
      for (int d = 0; d < 4; d++)
      begin
         link(1'b1, CMD_LOGSET, 0, 16'(d) << BIT_DEPTH_LO);
         tickGap();
         tickGap();
         check("interval", 16'(ivl[d] * MSC), 16'(n));
         check("depth", 16'(d), {14'h0, depthSel});
      end
      link(1'b1, CMD_LOGSET, 0, 16'h0040);
      @(posedge sys_clk);
      faultLow <= 1'b1;
      waitBit(0);
      check("shutdown", 16'h0001, {15'h0, shutdown});
      pulse(0);
      faultLow <= 1'b0;
      faultIgn <= 1'b1;
      @(posedge sys_clk);
      faultLow <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 check("ign", 16'h0, {14'h0, writeReq, shutdown});
      link(1'b1, CMD_LOGSET, 0, 16'h8000);
      waitBit(0);
      readChk("force", CMD_LOGSET, 0, 16'h8000);
      pulse(1);
      readChk("force done", CMD_LOGSET, 0, 16'h0000);
      check("cml", 16'h0001, {15'h0, cmlFlag});
      pulse(2);
      #1 check("cml clr", 16'h0000, {15'h0, cmlFlag});
      link(1'b1, CMD_LOGSET, 0, 16'h8400);
      waitBit(1);
      check("fresh first", 16'h0000, {15'h0, writeReq});
      sampleIn(1'b0, 16'h0100);
      waitBit(0);
      pulse(0);
      logFull <= 1'b1;
      link(1'b1, CMD_LOGSET, 0, 16'h8000);
      readChk("full", CMD_LOGSET, 0, 16'h0000);
      check("full write", 16'h0000, {15'h0, writeReq});
      link(1'b1, CMD_LOGSET, 0, 16'h8200);
      waitBit(0);
      pulse(0);
      logFull <= 1'b0;
      link(1'b1, CMD_LOGSET, 0, 16'h4000);
      waitBit(2);
      waitBit(3);
      regWrite(HA_WDATA, 16'h1111);
      regWrite(HA_ORDER, {4'h1, 4'h0, CMD_VMIN});
      regRead(HA_STATUS, rd);
      check("held", 16'h0005, rd & 16'h0007);
      pulse(0);
      pollIdle();
      readChk("erase done", CMD_LOGSET, 0, 16'h0000);
      readChk("held write", CMD_VMIN, 0, 16'h1111);
      summarize();
   end
   function automatic logic [15:0] pmEn_fix();
      return 16'hA5C3;
   endfunction : pmEn_fix
endmodule : tb
`default_nettype wire

// File: verilog/ssl_cmd_if.sv
// Command link between the host controller and the monitor's registers.
`timescale 1ns/1ps
`default_nettype none
interface ssl_cmd_if;
   logic        cmdValid;
   logic        cmdWrite;
   logic [7:0]  cmdCode;
   logic [3:0]  cmdPage;
   logic [15:0] cmdData;
   logic        rspValid;
   logic [15:0] rspData;
   logic        devBusy;
   modport dev  (input cmdValid, cmdWrite, cmdCode, cmdPage, cmdData,
                 output rspValid, rspData, devBusy);
   modport host (output cmdValid, cmdWrite, cmdCode, cmdPage, cmdData,
                 input rspValid, rspData, devBusy);
endinterface : ssl_cmd_if
`default_nettype wire

// File: verilog/ssl_device.sv
// Monitor end: slot table, trackers and nonvolatile log setup.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ssl_device
#(
   parameter int NCH       = 16,
   parameter int MS_CYC    = 100000
)
(
   input  wire logic                  sys_clk,
   input  wire logic                  rstn,
   ssl_cmd_if.dev                     bus,
   input  wire logic                  slotSequencingSelect,
   input  wire logic                  sequenceRun,
   input  wire logic [3:0]            activeSlot,
   input  wire logic [NCH-1:0]        pmbusEnable,
   output logic      [NCH-1:0]        supplyEnableOutput,
   input  wire logic                  voltValid,
   input  wire logic [3:0]            voltChan,
   input  wire logic [15:0]           voltSample,
   input  wire logic                  tempValid,
   input  wire logic [15:0]           tempSample,
   input  wire logic                  faultLineLow,
   input  wire logic                  faultIgnore,
   output logic                       globalShutdown,
   input  wire logic                  clearCml,
   output logic                       commMemoryLogicFlag,
   output logic                       collectTick,
   output logic                       freshSampleReq,
   output logic                       logWriteReq,
   output logic                       logEraseReq,
   output logic                       logEraseTwo,
   output logic      [1:0]            logDepthSelect,
   input  wire logic                  logFull,
   input  wire logic                  nvDone,
   input  wire logic                  nvFail,
   output logic                       monitorHalt
);
   import ssl_pkg::*;

   logic [3:0]  slot [NCH];
   logic [15:0] logSet;
   logic [15:0] tMean;
   logic        meanRestart;
   logic        alarmPend;
   logic        faultPrev;
   logic [31:0] msCnt;
   logic [7:0]  ivCnt;
   ssl_log_e    logState;
   ssl_log_e    next_logState;
   logic [15:0] vPeak [NCH];
   logic [15:0] vMin  [NCH];
   logic [15:0] tPeak;

   wire        wr       = bus.cmdValid && bus.cmdWrite && !monitorHalt;
   wire        rd       = bus.cmdValid && !bus.cmdWrite;
   wire        wrSlot   = wr && (bus.cmdCode == CMD_SLOT);
   wire        wrVPeak  = wr && (bus.cmdCode == CMD_VPEAK);
   wire        wrTPeak  = wr && (bus.cmdCode == CMD_TPEAK);
   wire        wrVMin   = wr && (bus.cmdCode == CMD_VMIN);
   wire        wrLogSet = wr && (bus.cmdCode == CMD_LOGSET);
   wire        wrMean   = wr && (bus.cmdCode == CMD_TMEAN);
   wire        vTake    = voltValid && !monitorHalt;
   wire        tTake    = tempValid && !monitorHalt;
   wire        alarmHit = faultLineLow && !faultIgnore;
   wire        wrapOn   = logSet[BIT_WRAP];
   wire        logBlock = logFull && !wrapOn;
   wire [1:0]  depthSel = logSet[BIT_DEPTH_LO +: 2];
   wire        msTick   = (msCnt == 32'(MS_CYC - 1)) && !monitorHalt;
   wire [7:0]  ivLast;
   wire [15:0] readValue;
   wire [16:0] tSampleX = {tempSample[15], tempSample};
   wire [16:0] tMeanX   = {tMean[15], tMean};
   wire signed [16:0] meanDiff = 17'($signed(tSampleX))
                                 - 17'($signed(tMeanX));
   wire [16:0] meanStep = 17'(meanDiff >>> MEAN_SHIFT);
   wire [15:0] meanNext = 16'(tMeanX + meanStep);

   // Interval per depth code; the log then spans five intervals.
   assign ivLast = (depthSel == 2'b00) ? 8'(INTERVAL_MS0 - 1) :
                   (depthSel == 2'b01) ? 8'(INTERVAL_MS1 - 1) :
                   (depthSel == 2'b10) ? 8'(INTERVAL_MS2 - 1) :
                                         8'(INTERVAL_MS3 - 1);
   assign logDepthSelect   = depthSel;
   assign logEraseTwo      = wrapOn;
   assign globalShutdown   = alarmHit;
   assign monitorHalt      = (logState == LG_ERASE);
   assign bus.devBusy      = monitorHalt;

   // Slot ordering and the shared group starting at slot 0 are kept by
   // the host; this compare only needs each slot's own number.
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_chan
         wire slotDue = sequenceRun && (slot[gi] <= activeSlot);
         assign supplyEnableOutput[gi] = slotSequencingSelect ? slotDue
                                         : pmbusEnable[gi];

         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
               slot[gi] <= SLOT_RESET;
            else if (wrSlot && bus.cmdPage == 4'(gi))
               slot[gi] <= bus.cmdData[3:0];
         end

         ssl_tracker #(.W(16), .TRACK_MAX(1'b1), .RESET_VAL(VPEAK_RESET))
         u_vpeak
         (
            .sys_clk     (sys_clk),
            .rstn        (rstn),
            .load        (wrVPeak && bus.cmdPage == 4'(gi)),
            .loadValue   (bus.cmdData),
            .sampleValid (vTake && voltChan == 4'(gi)),
            .sample      (voltSample),
            .value       (vPeak[gi])
         );

         ssl_tracker #(.W(16), .TRACK_MAX(1'b0), .RESET_VAL(VMIN_RESET))
         u_vmin
         (
            .sys_clk     (sys_clk),
            .rstn        (rstn),
            .load        (wrVMin && bus.cmdPage == 4'(gi)),
            .loadValue   (bus.cmdData),
            .sampleValid (vTake && voltChan == 4'(gi)),
            .sample      (voltSample),
            .value       (vMin[gi])
         );
      end
   endgenerate

   ssl_tracker #(.W(16), .TRACK_MAX(1'b1), .RESET_VAL(TPEAK_RESET)) u_tpeak
   (
      .sys_clk     (sys_clk),
      .rstn        (rstn),
      .load        (wrTPeak),
      .loadValue   (bus.cmdData),
      .sampleValid (tTake),
      .sample      (tempSample),
      .value       (tPeak)
   );

   // Unknown commands read back as zero.
   assign readValue =
      (bus.cmdCode == CMD_SLOT)   ? {12'h000, slot[bus.cmdPage]} :
      (bus.cmdCode == CMD_VPEAK)  ? vPeak[bus.cmdPage] :
      (bus.cmdCode == CMD_TPEAK)  ? tPeak :
      (bus.cmdCode == CMD_VMIN)   ? vMin[bus.cmdPage] :
      (bus.cmdCode == CMD_LOGSET) ? (logSet & LOGSET_MASK) :
      (bus.cmdCode == CMD_TMEAN)  ? tMean : 16'h0000;

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bus.rspValid <= 1'b0;
         bus.rspData  <= 16'h0000;
      end
      else
      begin
         bus.rspValid <= rd;
         bus.rspData  <= rd ? readValue : 16'h0000;
      end
   end

   // A restart makes the next sample the new mean.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tMean       <= TMEAN_RESET;
         meanRestart <= 1'b1;
      end
      else if (wrMean)
      begin
         if (bus.cmdData == 16'h0000)
            meanRestart <= 1'b1;
      end
      else if (tTake)
      begin
         tMean       <= meanRestart ? tempSample : meanNext;
         meanRestart <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         msCnt       <= 32'h0000_0000;
         ivCnt       <= 8'h00;
         collectTick <= 1'b0;
      end
      else
      begin
         collectTick <= 1'b0;
         if (!monitorHalt)
            msCnt <= msTick ? 32'h0000_0000 : msCnt + 32'h0000_0001;
         if (msTick)
         begin
            collectTick <= (ivCnt >= ivLast);
            ivCnt       <= (ivCnt >= ivLast) ? 8'h00 : ivCnt + 8'h01;
         end
      end
   end

   always_comb
   begin
      next_logState = logState;
      case (logState)
         LG_IDLE:
            if (logSet[BIT_ERASE])
               next_logState = LG_ERASE;
            else if ((logSet[BIT_FORCE] || alarmPend) && !logBlock)
               next_logState = logSet[BIT_FRESH] ? LG_FRESH
                                                 : LG_WRITE;
         LG_FRESH:
            if (voltValid)
               next_logState = LG_WRITE;
         LG_WRITE, LG_ERASE:
            if (nvDone || nvFail)
               next_logState = LG_IDLE;
         default:
            next_logState = LG_IDLE;
      endcase
   end

   assign freshSampleReq = (logState == LG_FRESH);
   assign logWriteReq    = (logState == LG_WRITE);
   assign logEraseReq    = (logState == LG_ERASE);

   wire actEnd  = (logWriteReq || logEraseReq) && (nvDone || nvFail);
   wire dropped = (logState == LG_IDLE) && logBlock && !logSet[BIT_ERASE];

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         logState  <= LG_IDLE;
         logSet    <= LOGSET_RESET;
         alarmPend <= 1'b0;
         faultPrev <= 1'b0;
         commMemoryLogicFlag <= 1'b0;
      end
      else
      begin
         logState  <= next_logState;
         faultPrev <= faultLineLow;
         if (wrLogSet)
            logSet <= bus.cmdData & LOGSET_MASK;
         else if (actEnd && logEraseReq)
            logSet[BIT_ERASE] <= 1'b0;
         else if ((actEnd && logWriteReq) || dropped)
            logSet[BIT_FORCE] <= 1'b0;
         if (faultLineLow && !faultPrev && logSet[BIT_ALARM] && !faultIgnore)
            alarmPend <= 1'b1;
         else if (logWriteReq || dropped)
            alarmPend <= 1'b0;
         if (actEnd && nvFail)
            commMemoryLogicFlag <= 1'b1;
         else if (clearCml)
            commMemoryLogicFlag <= 1'b0;
      end
   end
endmodule : ssl_device
`default_nettype wire

// File: verilog/ssl_host.sv
// Host end: software register port turned into link commands.
`timescale 1ns/1ps
`default_nettype none
module ssl_host
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   ssl_cmd_if.host          bus,
   input  wire logic [1:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [15:0] regRdata
);
   import ssl_pkg::*;

   logic [15:0] order;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        pending;
   logic        waitRsp;

   wire launch  = pending && !bus.devBusy;
   wire wrOrder = regWr && (regAddr == HA_ORDER);
   wire wrWdata = regWr && (regAddr == HA_WDATA);
   wire [15:0] statusWord = {13'h0000, bus.devBusy, waitRsp, pending};
   wire [15:0] readMux = (regAddr == HA_ORDER)  ? order :
                         (regAddr == HA_WDATA)  ? wdata :
                         (regAddr == HA_STATUS) ? statusWord : rdata;

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         order        <= 16'h0000;
         wdata        <= 16'h0000;
         rdata        <= 16'h0000;
         pending      <= 1'b0;
         waitRsp      <= 1'b0;
         regRdata     <= 16'h0000;
         bus.cmdValid <= 1'b0;
         bus.cmdWrite <= 1'b0;
         bus.cmdCode  <= 8'h00;
         bus.cmdPage  <= 4'h0;
         bus.cmdData  <= 16'h0000;
      end
      else
      begin
         regRdata     <= regRd ? readMux : 16'h0000;
         bus.cmdValid <= 1'b0;
         if (wrWdata)
            wdata <= regWdata;
         // An order written while one is still queued replaces it.
         if (wrOrder)
         begin
            order   <= regWdata;
            pending <= 1'b1;
         end
         else if (launch)
            pending <= 1'b0;
         if (launch)
         begin
            bus.cmdValid <= 1'b1;
            bus.cmdWrite <= order[ORD_WRITE_BIT];
            bus.cmdCode  <= order[7:0];
            bus.cmdPage  <= order[11:8];
            bus.cmdData  <= wdata;
            waitRsp      <= !order[ORD_WRITE_BIT];
         end
         else if (bus.rspValid)
         begin
            rdata   <= bus.rspData;
            waitRsp <= 1'b0;
         end
      end
   end
endmodule : ssl_host
`default_nettype wire

// File: verilog/ssl_pkg.sv
// Shared constants for the sequencing slot, tracker and log setup block.
package ssl_pkg;
   localparam logic [7:0]  CMD_SLOT       = 8'hD3;
   localparam logic [7:0]  CMD_VPEAK      = 8'hD4;
   localparam logic [7:0]  CMD_TPEAK      = 8'hD6;
   localparam logic [7:0]  CMD_VMIN       = 8'hD7;
   localparam logic [7:0]  CMD_LOGSET     = 8'hD8;
   localparam logic [7:0]  CMD_TMEAN      = 8'hE3;
   localparam int          SLOT_W         = 4;
   localparam int          DATA_W         = 16;
   localparam int          NUM_CHAN       = 16;
   localparam int          BIT_FORCE      = 15;
   localparam int          BIT_ERASE      = 14;
   localparam int          BIT_FRESH      = 10;
   localparam int          BIT_WRAP       = 9;
   localparam int          BIT_DEPTH_LO   = 7;
   localparam int          BIT_ALARM      = 6;
   localparam logic [15:0] LOGSET_MASK    = 16'hC7C0;
   localparam logic [15:0] LOGSET_RESET   = 16'h0000;
   localparam logic [15:0] VPEAK_RESET    = 16'h0000;
   localparam logic [15:0] TPEAK_RESET    = 16'h8000;
   localparam logic [15:0] VMIN_RESET     = 16'h7FFF;
   localparam logic [15:0] TMEAN_RESET    = 16'h0000;
   localparam logic [3:0]  SLOT_RESET     = 4'h0;
   localparam int          MEAN_SHIFT     = 3;
   localparam int          CLK_MHZ        = 100;
   localparam int          MS_CYCLES      = CLK_MHZ * 1000;
   localparam int          INTERVAL_MS0   = 5;
   localparam int          INTERVAL_MS1   = 20;
   localparam int          INTERVAL_MS2   = 80;
   localparam int          INTERVAL_MS3   = 160;
   localparam int          DEPTH_MS0      = 25;
   localparam int          DEPTH_MS1      = 100;
   localparam int          DEPTH_MS2      = 400;
   localparam int          DEPTH_MS3      = 800;
   localparam logic [7:0]  ERASE_FILL     = 8'hFF;
   localparam logic [1:0]  HA_ORDER       = 2'h0;
   localparam logic [1:0]  HA_WDATA       = 2'h1;
   localparam logic [1:0]  HA_STATUS      = 2'h2;
   localparam logic [1:0]  HA_RDATA       = 2'h3;
   localparam int          ORD_WRITE_BIT  = 12;
   typedef enum logic [1:0] {
      LG_IDLE  = 2'b00,
      LG_FRESH = 2'b01,
      LG_WRITE = 2'b10,
      LG_ERASE = 2'b11
   } ssl_log_e;
endpackage : ssl_pkg

// File: verilog/ssl_tracker.sv
// Peak or minimum tracker with a host-loadable reference value.
`timescale 1ns/1ps
`default_nettype none
module ssl_tracker
#(
   parameter int          W         = 16,
   parameter bit          TRACK_MAX = 1'b1,
   parameter logic [15:0] RESET_VAL = 16'h0000
)
(
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic         load,
   input  wire logic [W-1:0] loadValue,
   input  wire logic         sampleValid,
   input  wire logic [W-1:0] sample,
   output logic      [W-1:0] value
);
   wire beyond;

   // Values are two's complement, so 8000h is the lowest and 7FFFh the top.
   assign beyond = TRACK_MAX ? ($signed(sample) > $signed(value))
                             : ($signed(sample) < $signed(value));

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         value <= RESET_VAL[W-1:0];
      else if (load)
         value <= loadValue;
      else if (sampleValid && beyond)
         value <= sample;
   end
endmodule : ssl_tracker
`default_nettype wire
